// file: rtl/adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;
    localparam int RES_W      = 16;
    localparam int SPAN_W     = 3;
    localparam int WORD_W     = RES_W + 1 + SPAN_W;
    localparam int FRAME_W    = 2 * WORD_W;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_W     = 11;
    localparam int WORD_CHAN  = SPAN_W;
    localparam int WORD_RES   = SPAN_W + 1;
    localparam logic [3:0]  MSB_IDX   = 4'hf;
    localparam logic [3:0]  LSB_IDX   = 4'h0;
    localparam logic [15:0] MSB_CODE  = 16'h8000;
    localparam logic [15:0] ZERO_RES  = 16'h0000;
    localparam logic [15:0] LSB_MASK  = 16'h0001;
    localparam logic [2:0]  SPAN_OFF  = 3'h0;
    localparam logic [2:0]  SPAN_BP_7 = 3'h7;
    localparam logic [2:0]  SPAN_BP_6 = 3'h6;
    localparam logic [2:0]  SPAN_BP_3 = 3'h3;
    localparam logic [2:0]  SPAN_BP_2 = 3'h2;

    typedef enum logic [1:0] {TRACK, CONVERT, STAGE0, STAGE1} conv_state_t;

    function automatic logic span_bipolar(input logic [2:0] s);
        return (s == SPAN_BP_7) || (s == SPAN_BP_6) || (s == SPAN_BP_3) || (s == SPAN_BP_2);
    endfunction
endpackage
`default_nettype wire

// file: rtl/dual_sar_adc_conversion_control.sv
`default_nettype none
// ************************************************
// Result FIFO
// ************************************************
module result_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready_out  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid_out = (wr_ptr != rd_ptr);
    assign out_data_out  = mem[rd_ptr[AW-1:0]];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
                mem[i] <= '0;
            end else if (push && (wr_ptr[AW-1:0] == AW'(i))) begin
                mem[i] <= in_data_in;
            end
        end
    end
endmodule

// ************************************************
// Conversion control
// ************************************************
// Functional notes
// - A rising convert edge puts both channels into hold together and starts a conversion.
// - Each channel is resolved in turn by a 16-step binary search from half scale down to one LSB.
// - Results are staged for readout only after both channels are done.
// - Every result is a 16-bit code covering the whole selected range.
// - Bipolar span codes 111, 110, 011 and 010 give two's complement results.
// - Unipolar span codes 101, 100 and 001 give straight binary results.
// - Each channel keeps its own span, taken anew at every conversion start.
// - A disabled channel is skipped so the enabled one converts faster.
// - The held samples are dropped after each conversion and tracking resumes.
// - Nap and power-down states cut consumption while idle.
// - A mode pin, not a register, chooses between CMOS and LVDS serial output.
// - In CMOS mode the result may leave on one lane or two.
// - Readout sends the queued result pairs in conversion order, oldest first, with span information, channel 0 first.
module dual_sar_adc_conversion_control (
    input  wire logic        sys_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        convert_start_in,
    input  wire logic        comparator_in,
    input  wire logic [2:0]  span0_in,
    input  wire logic [2:0]  span1_in,
    input  wire logic        nap_in,
    input  wire logic        power_down_in,
    input  wire logic        lvds_mode_in,
    input  wire logic        two_lane_in,
    input  wire logic        serial_shift_clock_in,
    input  wire logic        chip_select_n_in,
    output logic             hold_out,
    output logic             busy_out,
    output logic             dac_chan_out,
    output logic [15:0]      dac_code_out,
    output logic             nap_active_out,
    output logic             power_down_active_out,
    output logic             lvds_mode_out,
    output logic [1:0]       serial_result_out,
    output logic [1:0]       serial_result_oe_out
);
    localparam int W = adc_ctrl_pkg::WORD_W;
    localparam int F = adc_ctrl_pkg::FRAME_W;

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [adc_ctrl_pkg::SYNC_W-1:0] pin_meta;
    logic [adc_ctrl_pkg::SYNC_W-1:0] pin_sync;
    logic                            cnv_prev;
    logic                            cnv_s;
    logic                            nap_s;
    logic                            pd_s;
    logic                            lvds_s;
    logic                            two_s;
    logic [2:0]                      span0_s;
    logic [2:0]                      span1_s;
    logic                            start;

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_meta <= '0;
            pin_sync <= '0;
            cnv_prev <= 1'b0;
        end else begin
            pin_meta <= {convert_start_in, nap_in, power_down_in, lvds_mode_in, two_lane_in, span1_in, span0_in};
            pin_sync <= pin_meta;
            cnv_prev <= cnv_s;
        end
    end

    assign {cnv_s, nap_s, pd_s, lvds_s, two_s, span1_s, span0_s} = pin_sync;
    // Power-down ignores convert edges; nap still lets them through
    assign start = cnv_s && !cnv_prev && !pd_s;

    // ************************************************
    // Successive approximation
    // ************************************************
    adc_ctrl_pkg::conv_state_t state;
    adc_ctrl_pkg::conv_state_t next_state;
    logic        chan;
    logic        next_chan;
    logic [3:0]  bit_idx;
    logic [3:0]  next_bit_idx;
    logic [15:0] trial;
    logic [15:0] next_trial;
    logic [15:0] res [2];
    logic [15:0] next_res [2];
    logic [2:0]  span_l [2];
    logic [2:0]  next_span_l [2];
    logic [15:0] mask;
    logic [15:0] keep;
    logic        fifo_in_ready;
    logic        fifo_in_valid;
    logic        stage_idx;
    logic [W-1:0] fifo_in_data;

    assign mask = adc_ctrl_pkg::LSB_MASK << bit_idx;
    assign keep = comparator_in ? trial : (trial & ~mask);

    always_comb begin
        next_state   = state;
        next_chan    = chan;
        next_bit_idx = bit_idx;
        next_trial   = trial;
        next_res     = res;
        next_span_l  = span_l;
        case (state)
            adc_ctrl_pkg::TRACK: begin
                if (start) begin
                    // Old results are dropped so nothing carries over
                    next_res[0]    = adc_ctrl_pkg::ZERO_RES;
                    next_res[1]    = adc_ctrl_pkg::ZERO_RES;
                    next_span_l[0] = span0_s;
                    next_span_l[1] = span1_s;
                    next_bit_idx   = adc_ctrl_pkg::MSB_IDX;
                    next_trial     = adc_ctrl_pkg::MSB_CODE;
                    if (span0_s != adc_ctrl_pkg::SPAN_OFF) begin
                        next_state = adc_ctrl_pkg::CONVERT;
                        next_chan  = 1'b0;
                    end else if (span1_s != adc_ctrl_pkg::SPAN_OFF) begin
                        next_state = adc_ctrl_pkg::CONVERT;
                        next_chan  = 1'b1;
                    end else begin
                        next_state = adc_ctrl_pkg::STAGE0;
                    end
                end
            end
            adc_ctrl_pkg::CONVERT: begin
                if (bit_idx == adc_ctrl_pkg::LSB_IDX) begin
                    // SAR runs offset binary; flipping the MSB gives two's complement
                    next_res[chan] = adc_ctrl_pkg::span_bipolar(span_l[chan]) ?
                                     {~keep[15], keep[14:0]} : keep;
                    next_bit_idx   = adc_ctrl_pkg::MSB_IDX;
                    next_trial     = adc_ctrl_pkg::MSB_CODE;
                    if (!chan && (span_l[1] != adc_ctrl_pkg::SPAN_OFF)) begin
                        next_chan = 1'b1;
                    end else begin
                        next_state = adc_ctrl_pkg::STAGE0;
                    end
                end else begin
                    next_bit_idx = 4'(bit_idx - 4'h1);
                    next_trial   = keep | (mask >> 1);
                end
            end
            adc_ctrl_pkg::STAGE0: begin
                if (fifo_in_ready) begin
                    next_state = adc_ctrl_pkg::STAGE1;
                end
            end
            adc_ctrl_pkg::STAGE1: begin
                if (fifo_in_ready) begin
                    next_state = adc_ctrl_pkg::TRACK;
                end
            end
            default: begin
                next_state = adc_ctrl_pkg::TRACK;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state     <= adc_ctrl_pkg::TRACK;
            chan      <= 1'b0;
            bit_idx   <= adc_ctrl_pkg::MSB_IDX;
            trial     <= adc_ctrl_pkg::MSB_CODE;
            res[0]    <= adc_ctrl_pkg::ZERO_RES;
            res[1]    <= adc_ctrl_pkg::ZERO_RES;
            span_l[0] <= adc_ctrl_pkg::SPAN_OFF;
            span_l[1] <= adc_ctrl_pkg::SPAN_OFF;
        end else begin
            state     <= next_state;
            chan      <= next_chan;
            bit_idx   <= next_bit_idx;
            trial     <= next_trial;
            res       <= next_res;
            span_l    <= next_span_l;
        end
    end

    assign hold_out              = (state == adc_ctrl_pkg::CONVERT);
    assign busy_out              = (state != adc_ctrl_pkg::TRACK);
    assign dac_chan_out          = chan;
    assign dac_code_out          = trial;
    assign nap_active_out        = nap_s && !pd_s && (state == adc_ctrl_pkg::TRACK);
    assign power_down_active_out = pd_s && (state == adc_ctrl_pkg::TRACK);
    assign lvds_mode_out         = lvds_s;

    // ************************************************
    // Staging and drain toward the link
    // ************************************************
    logic         fifo_out_valid;
    logic         fifo_out_ready;
    logic [W-1:0] fifo_out_data;
    logic [F-1:0] hold_pair;
    logic [F-1:0] next_hold_pair;
    logic         req;
    logic         next_req;
    logic         ack;
    logic         ack_meta;
    logic         ack_sync;

    assign stage_idx     = (state == adc_ctrl_pkg::STAGE1);
    assign fifo_in_valid = (state == adc_ctrl_pkg::STAGE0) || stage_idx;
    assign fifo_in_data  = {res[stage_idx], stage_idx, span_l[stage_idx]};

    result_fifo #(.WIDTH(W), .DEPTH(adc_ctrl_pkg::FIFO_DEPTH)) u_fifo (
        .clk_in       (sys_clk_in),
        .arst_n_in    (arst_n_in),
        .in_valid_in  (fifo_in_valid),
        .in_ready_out (fifo_in_ready),
        .in_data_in   (fifo_in_data),
        .out_valid_out(fifo_out_valid),
        .out_ready_in (fifo_out_ready),
        .out_data_out (fifo_out_data)
    );

    // Holding pair may change only while the link has acknowledged it
    assign fifo_out_ready = (req == ack_sync);

    always_comb begin
        next_hold_pair = hold_pair;
        next_req       = req;
        if (fifo_out_valid && fifo_out_ready) begin
            if (fifo_out_data[adc_ctrl_pkg::WORD_CHAN]) begin
                next_hold_pair[W-1:0] = fifo_out_data;
                next_req              = ~req;
            end else begin
                next_hold_pair[F-1:W] = fifo_out_data;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hold_pair <= '0;
            req       <= 1'b0;
            ack_meta  <= 1'b0;
            ack_sync  <= 1'b0;
        end else begin
            hold_pair <= next_hold_pair;
            req       <= next_req;
            ack_meta  <= ack;
            ack_sync  <= ack_meta;
        end
    end

    // ************************************************
    // Link domain
    // ************************************************
    logic         req_meta;
    logic         req_sync;
    logic         next_ack;
    logic [F-1:0] latest;
    logic [F-1:0] next_latest;
    logic         loaded;
    logic [F-1:0] shreg;
    logic [F-1:0] next_shreg;
    logic         frame_rst_n;
    logic         fresh;

    // The shift clock stops between frames, so the frame ends through chip select
    assign frame_rst_n = arst_n_in && !chip_select_n_in;
    assign fresh       = (req_sync != ack);

    always_comb begin
        next_ack    = ack;
        next_latest = latest;
        next_shreg  = shreg << 1;
        if (!loaded) begin
            if (fresh) begin
                next_ack    = req_sync;
                next_latest = hold_pair;
            end
            next_shreg = next_latest;
        end
    end

    always_ff @(posedge serial_shift_clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            ack      <= 1'b0;
            latest   <= '0;
        end else begin
            req_meta <= req;
            req_sync <= req_meta;
            ack      <= next_ack;
            latest   <= next_latest;
        end
    end

    always_ff @(posedge serial_shift_clock_in or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            loaded <= 1'b0;
            shreg  <= '0;
        end else begin
            loaded <= 1'b1;
            shreg  <= next_shreg;
        end
    end

    // Lane 1 carries channel 1 in parallel; one lane sends both words in turn
    assign serial_result_out    = {shreg[W-1], shreg[F-1]};
    assign serial_result_oe_out = {!chip_select_n_in && !lvds_s && two_s, !chip_select_n_in};

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    chk_start_holds: assert property (start && state == adc_ctrl_pkg::TRACK && span0_s != 3'h0 |=> hold_out)
        else $error("convert edge did not enter hold");
    chk_bit_step: assert property (hold_out && bit_idx != 4'h0 |=> hold_out && bit_idx == $past(bit_idx) - 4'h1)
        else $error("SAR step skipped");
    chk_stage_late: assert property (fifo_in_valid |-> !hold_out)
        else $error("staging during conversion");
    chk_bipolar_msb: assert property (hold_out && bit_idx == 4'h0 && adc_ctrl_pkg::span_bipolar(span_l[chan])
        |=> res[$past(chan)][15] == !$past(keep[15]))
        else $error("bipolar result not two's complement");
    chk_unipolar_code: assert property (hold_out && bit_idx == 4'h0 && !adc_ctrl_pkg::span_bipolar(span_l[chan])
        |=> res[$past(chan)] == $past(keep))
        else $error("unipolar result not straight binary");
    chk_span_frozen: assert property (busy_out && $past(busy_out) |-> $stable(span_l[0]) && $stable(span_l[1]))
        else $error("span changed mid conversion");
    chk_skip_disabled: assert property (start && state == adc_ctrl_pkg::TRACK && span0_s == 3'h0 && span1_s != 3'h0
        |=> hold_out && dac_chan_out)
        else $error("disabled channel not skipped");
    chk_clear_sample: assert property (start && state == adc_ctrl_pkg::TRACK |=> res[0] == 16'h0000 ##0 res[1] == 16'h0000)
        else $error("old result carried over");
    chk_pd_ignore: assert property (pd_s && state == adc_ctrl_pkg::TRACK |=> !busy_out)
        else $error("converted in power-down");
    chk_lvds_lane: assert property (lvds_s |-> !serial_result_oe_out[1])
        else $error("second lane driven in LVDS mode");
    chk_zero_word: assert property (fifo_in_valid && fifo_in_data[2:0] == 3'h0 |-> fifo_in_data[W-1:4] == 16'h0000)
        else $error("disabled channel result not zero");

    cov_dual: cover property (start && span0_s != 3'h0 && span1_s != 3'h0 ##[1:40] fifo_in_valid);
    cov_single: cover property (start && span0_s == 3'h0 && span1_s != 3'h0);
    cov_full: cover property (fifo_in_valid && !fifo_in_ready);
endmodule
`default_nettype wire

// file: tb/adc_host_model.sv
`default_nettype none
// ****
// Host side: analog levels and serial frame reader
// ****
module adc_host_model (
    input  wire logic        dac_chan_in,
    input  wire logic [15:0] dac_code_in,
    input  wire logic [15:0] level0_in,
    input  wire logic [15:0] level1_in,
    input  wire logic        frame_req_in,
    input  wire logic [5:0]  frame_len_in,
    input  wire logic [1:0]  serial_result_in,
    input  wire logic [1:0]  serial_result_oe_in,
    output logic             comparator_out,
    output logic             shift_clk_out,
    output logic             select_n_out,
    output logic [39:0]      lane0_out,
    output logic [19:0]      lane1_out,
    output logic [1:0]       oe_seen_out,
    output logic             frame_done_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // High while the held input is at or above the trial code
    assign comparator_out = (dac_chan_in ? level1_in : level0_in) >= dac_code_in;

    // Clock idles low and stands still between frames, so the link side only moves inside frames
    initial begin
        shift_clk_out = 1'b0;
        select_n_out = 1'b1;
        frame_done_out = 1'b0;
        oe_seen_out = 2'h0;
        forever begin
            wait (frame_req_in === 1'b1);
            lane0_out = 40'h0;
            lane1_out = 20'h0;
            #7;
            select_n_out = 1'b0;
            #11;
            oe_seen_out = serial_result_oe_in;
            for (int k = 0; k < frame_len_in; k++) begin
                shift_clk_out = 1'b1;
                #15;
                shift_clk_out = 1'b0;
                lane0_out = {lane0_out[38:0], serial_result_in[0]};
                lane1_out = {lane1_out[18:0], serial_result_in[1]};
                #15;
            end
            select_n_out = 1'b1;
            frame_done_out = 1'b1;
            wait (frame_req_in === 1'b0);
            frame_done_out = 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk = 1'b0, arst_n = 1'b0, conv = 1'b0;
    logic        nap = 1'b0, pd = 1'b0, lvds = 1'b0, two_lane = 1'b0, req = 1'b0;
    logic [2:0]  span0 = 3'h0, span1 = 3'h0;
    logic [15:0] level0 = 16'h0, level1 = 16'h0, dcode;
    logic [5:0]  flen = 6'h28;
    logic        cmp, sclk, cs_n, hold, busy, dchan, nap_act, pd_act, lvds_o, done;
    logic [1:0]  sres, soe, oe_seen;
    logic [39:0] lane0;
    logic [19:0] lane1;
    int          err_count = 0, n_checks = 0;

    always #25 sys_clk = ~sys_clk;

    dual_sar_adc_conversion_control dual_sar_adc_conversion_control_inst (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n), .convert_start_in(conv), .comparator_in(cmp),
        .span0_in(span0), .span1_in(span1), .nap_in(nap), .power_down_in(pd), .lvds_mode_in(lvds),
        .two_lane_in(two_lane), .serial_shift_clock_in(sclk), .chip_select_n_in(cs_n),
        .hold_out(hold), .busy_out(busy), .dac_chan_out(dchan), .dac_code_out(dcode),
        .nap_active_out(nap_act), .power_down_active_out(pd_act), .lvds_mode_out(lvds_o),
        .serial_result_out(sres), .serial_result_oe_out(soe));

    adc_host_model adc_host_model_inst (
        .dac_chan_in(dchan), .dac_code_in(dcode), .level0_in(level0), .level1_in(level1),
        .frame_req_in(req), .frame_len_in(flen), .serial_result_in(sres), .serial_result_oe_in(soe),
        .comparator_out(cmp), .shift_clk_out(sclk), .select_n_out(cs_n), .lane0_out(lane0),
        .lane1_out(lane1), .oe_seen_out(oe_seen), .frame_done_out(done));

    // ****
    // Shared tasks
    // ****
    task automatic stop_test;
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check_val(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_cnt(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    function automatic logic [19:0] exp_word(input logic [2:0] s, input logic c, input logic [15:0] l);
        logic [15:0] r;
        r = (s == 3'h0) ? 16'h0000 : l;
        if (s inside {3'h7, 3'h6, 3'h3, 3'h2}) r = l ^ 16'h8000;
        return {r, c, s};
    endfunction

    task automatic convert(input logic [2:0] s0, s1, input logic [15:0] l0, l1, output int held);
        logic seen;
        seen = 1'b0;
        held = 0;
        span0 = s0;
        span1 = s1;
        level0 = l0;
        level1 = l1;
        cycles(3);
        conv = 1'b1;
        for (int i = 0; i < 80; i++) begin
            cycles(1);
            if (i == 2) conv = 1'b0;
            if (hold === 1'b1) held++;
            if (busy === 1'b1) seen = 1'b1;
            else if (seen) break;
        end
    endtask

    // Each frame also pumps the crossing, so a frame carries the pair whose request crossed during the frame before it
    task automatic read_frame(input logic [5:0] len);
        flen = len;
        req = 1'b1;
        for (int i = 0; i < 100 && done !== 1'b1; i++) cycles(1);
        req = 1'b0;
        for (int i = 0; i < 10 && done !== 1'b0; i++) cycles(1);
    endtask

    // ****
    // Scenarios
    // ****
    task automatic test_spans;
        int held;
        logic [15:0] l;
        for (int i = 0; i < 8; i++) begin
            l = 16'h1f3c * i[15:0];
            convert(i[2:0], 3'h7 - i[2:0], l, ~l, held);
            check_cnt(held, 16 * (int'(i != 0) + int'(i != 7)));
            read_frame(6'h28);
            read_frame(6'h28);
            check_val(lane0, {exp_word(i[2:0], 1'b0, l), exp_word(3'h7 - i[2:0], 1'b1, ~l)});
            check_val(40'(oe_seen), 40'h1);
        end
    endtask

    task automatic test_lanes;
        int held;
        two_lane = 1'b1;
        convert(3'h5, 3'h3, 16'hc001, 16'h4ffe, held);
        read_frame(6'h14);
        read_frame(6'h14);
        check_val(40'(lane0[19:0]), 40'(exp_word(3'h5, 1'b0, 16'hc001)));
        check_val(40'(lane1), 40'(exp_word(3'h3, 1'b1, 16'h4ffe)));
        check_val(40'(oe_seen), 40'h3);
        lvds = 1'b1;
        cycles(4);
        check_val(40'(lvds_o), 40'h1);
        read_frame(6'h14);
        check_val(40'(oe_seen), 40'h1);
        lvds = 1'b0;
        two_lane = 1'b0;
        cycles(4);
    endtask

    task automatic test_refuse;
        span0 = 3'h1;
        span1 = 3'h1;
        level0 = 16'h00ff;
        level1 = 16'hff00;
        cycles(3);
        conv = 1'b1;
        cycles(3);
        conv = 1'b0;
        cycles(10);
        // Second edge lands in mid conversion and must leave no trace
        conv = 1'b1;
        cycles(3);
        conv = 1'b0;
        for (int i = 0; i < 60 && busy !== 1'b0; i++) cycles(1);
        cycles(10);
        check_val(40'(busy), 40'h0);
        read_frame(6'h28);
        read_frame(6'h28);
        check_val(lane0, {exp_word(3'h1, 1'b0, 16'h00ff), exp_word(3'h1, 1'b1, 16'hff00)});
    endtask

    task automatic test_fifo_full;
        int held;
        // Holding pair plus four FIFO words absorb three pairs; the fourth stalls staging
        for (int i = 0; i < 4; i++) convert(3'h7, 3'h4, 16'h0100 << i, 16'h0abc, held);
        check_val(40'(busy), 40'h1);
        for (int i = 0; i < 4; i++) read_frame(6'h28);
        check_val(40'(busy), 40'h0);
        check_val(lane0, {exp_word(3'h7, 1'b0, 16'h0400), exp_word(3'h4, 1'b1, 16'h0abc)});
    endtask

    task automatic test_power;
        int held;
        pd = 1'b1;
        cycles(4);
        check_val(40'(pd_act), 40'h1);
        convert(3'h7, 3'h7, 16'h0001, 16'h0002, held);
        check_cnt(held, 0);
        pd = 1'b0;
        nap = 1'b1;
        cycles(4);
        check_val(40'({nap_act, pd_act}), 40'h2);
        nap = 1'b0;
        cycles(4);
        check_val(40'({nap_act, pd_act}), 40'h0);
    endtask

    task automatic test_async_reset;
        conv = 1'b1;
        cycles(8);
        conv = 1'b0;
        check_val(40'(busy), 40'h1);
        arst_n = 1'b0;
        cycles(1);
        check_val(40'({hold, busy, dchan, dcode}), 40'h08000);
        arst_n = 1'b1;
        cycles(3);
    endtask

    initial begin
        cycles(2);
        check_val(40'({hold, busy, dchan, dcode, soe}), 40'h20000);
        cycles(1);
        arst_n = 1'b1;
        cycles(3);
        test_spans;
        test_lanes;
        test_refuse;
        test_fifo_full;
        test_power;
        test_async_reset;
        stop_test;
    end

    // A full run needs under two thousand cycles; this leaves ample room
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        stop_test;
    end
endmodule
`default_nettype wire
